//--- rtl/abc_top.sv
// Burst sequencer and result accumulator for the SAR converter core.
// Assumes the core handshake and SFR port are synchronous to i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module abc_top #(
  parameter int unsigned PWRUP_STEP_CLKS = 4,
  parameter int unsigned BURST_DIV       = abc_pkg::BURST_DIV
) (
  input  wire logic                    i_sys_clk,     // System clock
  input  wire logic                    i_rst_n,       // Sync reset, low
  input  wire logic [7:0]              i_sfr_addr,    // SFR address
  input  wire logic                    i_sfr_wr,      // SFR write strobe
  input  wire logic                    i_sfr_rd,      // SFR read strobe
  input  wire logic [7:0]              i_sfr_wdata,   // SFR write data
  output logic [7:0]                   o_sfr_rdata,   // SFR read data
  input  wire logic                    i_burst_enable,    // Burst mode
  input  wire logic                    i_converter_enable, // Converter on
  input  wire logic [abc_pkg::PWR_W-1:0] i_power_up_time, // Wake time
  input  wire logic [abc_pkg::TK_W-1:0]  i_tracking_time, // Track time
  input  wire logic                    i_extra_tracking_mode, // +3 clks
  input  wire logic [abc_pkg::MUX_W-1:0] i_input_select_reg, // Channel
  input  wire logic                    i_convert_start, // Start pulse
  input  wire logic                    i_done_clear,  // Clear done flag
  output logic                         o_conversion_done_flag, // Done
  output logic                         o_window_strobe, // Compare now
  output logic [abc_pkg::RES_W-1:0]    o_result,      // Formatted result
  output logic [abc_pkg::MUX_W-1:0]    o_input_selector, // To mux
  output logic                         o_conv_power,  // Core powered
  output logic                         o_conv_track,  // Core tracking
  output logic                         o_conv_start,  // Core start pulse
  output logic                         o_twelve_bit,  // Core 12-bit mode
  input  wire logic                    i_conv_done,   // Core done pulse
  input  wire logic [abc_pkg::DATA_W-1:0] i_conv_data // Core result
);
  import abc_pkg::*;

  abc_state_t          state;
  abc_cfg_t            cfg;
  logic                acc_enable;
  logic                powered;
  logic [TMR_W-1:0]    tmr;
  logic [CNT_W-1:0]    cnt;
  logic [CNT_W-1:0]    total;
  logic [CNT_W-1:0]    next_cnt;
  logic [ACC_W-1:0]    acc;
  logic [ACC_W-1:0]    sample;
  logic [RES_W-1:0]    fmt;
  logic                tick;
  logic                accept;
  logic                conv_evt;
  logic                last;
  logic                done_pulse;
  logic                done_q;
  logic                tmr_end;
  logic [TMR_W-1:0]    pwr_load;
  logic [TMR_W-1:0]    trk_load;

  abc_burst_tick #(
    .DIV (BURST_DIV)
  ) u_tick (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  abc_result_format u_fmt (
    .i_acc    (acc),
    .i_cfg    (cfg),
    .o_total  (total),
    .o_result (fmt)
  );

  // Starts without burst need the converter already enabled.
  assign accept = (state == ST_IDLE) && i_convert_start &&
                  (i_burst_enable || i_converter_enable);
  assign conv_evt   = (state == ST_WAIT) && i_conv_done;
  assign next_cnt   = cnt + 1'b1;
  assign last       = (next_cnt == total);
  assign done_pulse = conv_evt && last;
  assign tmr_end    = tick && (tmr == '0);

  assign pwr_load = TMR_W'((32'(i_power_up_time) + 32'd1) *
                           PWRUP_STEP_CLKS - 32'd1);
  assign trk_load = TMR_W'(i_tracking_time);
  assign sample = ACC_W'(i_conv_data) & (cfg.twelve_bit_enable ?
                  ACC_W'(12'hfff) : ACC_W'(12'h3ff));

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cfg        <= abc_cfg_t'({ACC_CFG_RESET[BIT_TWELVE],
                               ACC_CFG_RESET[SJ_LSB +: 3],
                               ACC_CFG_RESET[RPT_LSB +: 3]});
      acc_enable <= ACC_CFG_RESET[BIT_ACC_EN];
    end else if (i_sfr_wr && i_sfr_addr == ADDR_ACC_CFG) begin
      cfg.twelve_bit_enable <= i_sfr_wdata[BIT_TWELVE];
      cfg.shift_justify     <= i_sfr_wdata[SJ_LSB +: 3];
      cfg.repeat_count      <= i_sfr_wdata[RPT_LSB +: 3];
      acc_enable            <= i_sfr_wdata[BIT_ACC_EN];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      unique case (i_sfr_addr)
        ADDR_ACC_CFG:  o_sfr_rdata <= {cfg.twelve_bit_enable, 1'b0,
                                       cfg.shift_justify,
                                       cfg.repeat_count};
        ADDR_RES_HIGH: o_sfr_rdata <= fmt[15:8];
        ADDR_RES_LOW:  o_sfr_rdata <= fmt[7:0];
        default:       o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      tmr   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept && i_burst_enable && !powered) begin
            state <= ST_PWRUP;
            tmr   <= pwr_load;
          end else if (accept) begin
            state <= ST_TRACK;
            tmr   <= trk_load;
          end
        end
        ST_PWRUP: begin
          if (tmr_end) begin
            state <= ST_TRACK;
            tmr   <= trk_load;
          end else if (tick) begin
            tmr <= tmr - 1'b1;
          end
        end
        ST_TRACK: begin
          if (tmr_end && i_extra_tracking_mode) begin
            state <= ST_EXTRA;
            tmr   <= TMR_W'(EXTRA_TRACK_CLKS - 1);
          end else if (tmr_end) begin
            state <= ST_CONV;
          end else if (tick) begin
            tmr <= tmr - 1'b1;
          end
        end
        ST_EXTRA: begin
          if (tmr_end) begin
            state <= ST_CONV;
          end else if (tick) begin
            tmr <= tmr - 1'b1;
          end
        end
        ST_CONV: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (conv_evt && !last && i_burst_enable) begin
            state <= ST_TRACK;
            tmr   <= trk_load;
          end else if (conv_evt) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cnt <= '0;
    end else if (accept && (i_burst_enable || cnt == '0)) begin
      cnt <= '0;
    end else if (conv_evt) begin
      cnt <= last ? '0 : next_cnt;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      powered <= 1'b0;
    end else if (state == ST_PWRUP) begin
      powered <= 1'b1;
    end else if (done_pulse && i_burst_enable) begin
      powered <= i_converter_enable;
    end else if (state == ST_IDLE) begin
      if (i_converter_enable) begin
        powered <= 1'b1;
      end else if (!i_burst_enable) begin
        powered <= 1'b0;
      end
    end
  end

  // A finished conversion takes priority over a software result write.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      acc <= '0;
    end else if (conv_evt) begin
      if (i_burst_enable ? (cnt == '0) : !acc_enable) begin
        acc <= sample;
      end else begin
        acc <= acc + sample;
      end
    end else if (i_sfr_wr && i_sfr_addr == ADDR_RES_HIGH) begin
      acc <= {2'b00, i_sfr_wdata, acc[7:0]};
    end else if (i_sfr_wr && i_sfr_addr == ADDR_RES_LOW) begin
      acc <= {acc[ACC_W-1:8], i_sfr_wdata};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done_q                 <= 1'b0;
      o_window_strobe        <= 1'b0;
      o_conversion_done_flag <= 1'b0;
      o_result               <= '0;
    end else begin
      done_q          <= done_pulse;
      o_window_strobe <= done_q;
      o_result        <= fmt;
      if (done_q) begin
        o_conversion_done_flag <= 1'b1;
      end else if (i_done_clear) begin
        o_conversion_done_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_input_selector <= '0;
      o_conv_track     <= 1'b0;
      o_conv_start     <= 1'b0;
      o_twelve_bit     <= 1'b0;
    end else begin
      o_input_selector <= i_input_select_reg;
      o_conv_track     <= (state == ST_TRACK) || (state == ST_EXTRA);
      o_conv_start     <= (state == ST_CONV);
      o_twelve_bit     <= cfg.twelve_bit_enable;
    end
  end

  assign o_conv_power = powered;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_start_cold;
    accept && i_burst_enable && !powered;
  endsequence

  sequence seq_start_warm;
    accept && !(i_burst_enable && !powered);
  endsequence

  logic [2:0] extra_ticks;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || state != ST_EXTRA) begin
      extra_ticks <= '0;
    end else if (tick) begin
      extra_ticks <= extra_ticks + 1'b1;
    end
  end

  AST_COLD_START: assert property (
    seq_start_cold |=> state == ST_PWRUP)
    else $error("Cold start skipped the power-up wait.");

  AST_WARM_START: assert property (
    seq_start_warm |=> state == ST_TRACK)
    else $error("Warm start did not go straight to tracking.");

  AST_EXTRA_THREE: assert property (
    (state == ST_EXTRA) ##1 (state == ST_CONV) |-> extra_ticks == 3'd3)
    else $error("Extra tracking did not last three ticks.");

  AST_SINGLE_CONV: assert property (
    conv_evt && !i_burst_enable |=> state == ST_IDLE)
    else $error("Non-burst start ran more than one conversion.");

  AST_FLAG_AFTER: assert property (
    done_pulse |-> ##2 o_conversion_done_flag && o_window_strobe)
    else $error("Done flag not set after the last conversion.");

  AST_WINDOW_LATE: assert property (
    o_window_strobe |-> $past(done_pulse, 2))
    else $error("Window strobe came before the run completed.");

  AST_POWER_DOWN: assert property (
    done_pulse && i_burst_enable && !i_converter_enable |=> !powered)
    else $error("Converter stayed powered after the burst.");

  AST_STAY_ON: assert property (
    state == ST_IDLE && i_converter_enable |=> powered)
    else $error("Converter not kept powered between bursts.");

  AST_ACC_EN_ZERO: assert property (
    i_sfr_rd && i_sfr_addr == ADDR_ACC_CFG |=> !o_sfr_rdata[BIT_ACC_EN])
    else $error("Accumulate enable bit read back as one.");

  AST_CNT_CLEAR: assert property (
    accept && i_burst_enable |=> (cnt == '0) [*2])
    else $error("Conversion counter not cleared at burst start.");

endmodule
`default_nettype wire

//--- rtl/abc_pkg.sv
// Shared constants, field layouts and types for the burst/accumulate control.
// Assumes a single 125 MHz system clock and an SFR port on that clock.
package abc_pkg;

  localparam int unsigned SYS_CLK_HZ   = 125_000_000;
  localparam int unsigned BURST_CLK_HZ = 20_000_000;
  // Rounded down, so the tick runs slightly above the nominal rate.
  localparam int unsigned BURST_DIV    = SYS_CLK_HZ / BURST_CLK_HZ;

  localparam logic [7:0] ADDR_ACC_CFG  = 8'hba;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  localparam logic [7:0] ACC_CFG_RESET = 8'h00;

  localparam int unsigned BIT_TWELVE = 7;
  localparam int unsigned BIT_ACC_EN = 6;
  localparam int unsigned SJ_LSB     = 3;
  localparam int unsigned RPT_LSB    = 0;

  localparam logic [2:0] SJ_LEFT = 3'h4;

  localparam int unsigned EXTRA_TRACK_CLKS = 3;
  localparam int unsigned PWR_W  = 5;
  localparam int unsigned TK_W   = 4;
  localparam int unsigned TMR_W  = 8;
  localparam int unsigned CNT_W  = 7;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned ACC_W  = 18;
  localparam int unsigned RES_W  = 16;
  localparam int unsigned MUX_W  = 5;

  typedef struct packed {
    logic       twelve_bit_enable;
    logic [2:0] shift_justify;
    logic [2:0] repeat_count;
  } abc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PWRUP,
    ST_TRACK,
    ST_EXTRA,
    ST_CONV,
    ST_WAIT
  } abc_state_t;

endpackage

//--- rtl/abc_burst_tick.sv
// Divider that makes the burst sequencing tick from the system clock.
// Assumes the divide ratio is at least two.
`timescale 1ns/1ps
`default_nettype none
module abc_burst_tick #(
  parameter int unsigned DIV = abc_pkg::BURST_DIV
) (
  input  wire logic i_sys_clk,   // System clock
  input  wire logic i_rst_n,     // Synchronous reset, active low
  output logic      o_tick       // One-cycle burst tick
);
  import abc_pkg::*;

  localparam int unsigned W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_cnt;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      div_cnt <= '0;
      o_tick  <= 1'b0;
    end else begin
      o_tick  <= (div_cnt == LAST);
      div_cnt <= (div_cnt == LAST) ? '0 : div_cnt + 1'b1;
    end
  end

endmodule
`default_nettype wire

//--- rtl/abc_result_format.sv
// Decodes the repeat count and formats the accumulator for reading.
// Purely combinational; the caller registers the formatted result and uses the total unregistered.
`timescale 1ns/1ps
`default_nettype none
module abc_result_format (
  input  wire logic [abc_pkg::ACC_W-1:0] i_acc,    // Accumulator value
  input  wire abc_pkg::abc_cfg_t         i_cfg,    // Format settings
  output logic [abc_pkg::CNT_W-1:0]      o_total,  // Conversions per run
  output logic [abc_pkg::RES_W-1:0]      o_result  // Formatted result
);
  import abc_pkg::*;

  always_comb begin
    unique case (i_cfg.repeat_count)
      3'h1:    o_total = 7'h04;
      3'h2:    o_total = 7'h08;
      3'h3:    o_total = 7'h10;
      3'h4:    o_total = 7'h20;
      3'h5:    o_total = 7'h40;
      default: o_total = 7'h01;
    endcase
  end

  always_comb begin
    // Reserved codes read as unshifted right-justified data.
    unique case (i_cfg.shift_justify)
      3'h1:    o_result = i_acc[RES_W:1];
      3'h2:    o_result = i_acc[RES_W+1:2];
      3'h3:    o_result = {1'b0, i_acc[RES_W+1:3]};
      SJ_LEFT: o_result = i_cfg.twelve_bit_enable ?
                          {i_acc[11:0], 4'h0} : {i_acc[9:0], 6'h00};
      default: o_result = i_acc[RES_W-1:0];
    endcase
  end

endmodule
`default_nettype wire

//--- sim/abc_core_model.sv
// Behavioural model of the SAR core that answers each start pulse.
// Assumes start pulses arrive from the sequencer on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
module abc_core_model (
  input  wire logic        i_sys_clk,  // System clock
  input  wire logic        i_start,    // Start pulse from sequencer
  input  wire logic        i_slow,     // Answer late when high
  input  wire logic [11:0] i_value,    // Sample to return
  output logic             o_done,     // One-cycle done pulse
  output logic [11:0]      o_data      // Result, junk outside done
);
  logic       busy;
  logic [3:0] left;
  initial begin
    busy   = 1'b0;
    left   = 4'h0;
    o_done = 1'b0;
    o_data = 12'h000;
  end
  // Outside the done cycle the data bus toggles, so a sample one cycle after the done pulse reads inverted.
  always @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      busy <= 1'b1;
      left <= i_slow ? 4'hb : 4'h2;
    end else if (busy) begin
      left <= left - 4'h1;
      if (left == 4'h1) begin
        busy   <= 1'b0;
        o_done <= 1'b1;
        o_data <= i_value;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/abc_top_test.sv
// Self-checking bench for the burst sequencer and accumulator.
// Assumes abc_pkg and the core model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module abc_top_test;
  import abc_pkg::*;
  localparam int DIV = 2;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
  logic burst = 1'b0, cen = 1'b0, xtra = 1'b0, start = 1'b0;
  logic dclr = 1'b0, slow = 1'b0, done, win, pwr, trk, cst, tw;
  logic [4:0] pwt = 5'h00, sel = 5'h13, selo;
  logic [3:0] tk = 4'h1;
  logic [11:0] val = 12'h0a5, cdata;
  logic [15:0] res;
  logic cdone;
  int num_errors = 0, total_checks = 0, n_st = 0, n_win = 0, n_trk = 0;
  int lat, lc, lw, lx, lt, c;
  always #4 clk = ~clk;
  abc_top #(.BURST_DIV(DIV), .PWRUP_STEP_CLKS(4)) uut (
    .i_sys_clk(clk), .i_rst_n(rst_n),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_burst_enable(burst), .i_converter_enable(cen),
    .i_power_up_time(pwt), .i_tracking_time(tk),
    .i_extra_tracking_mode(xtra), .i_input_select_reg(sel),
    .i_convert_start(start), .i_done_clear(dclr),
    .o_conversion_done_flag(done), .o_window_strobe(win), .o_result(res),
    .o_input_selector(selo), .o_conv_power(pwr), .o_conv_track(trk),
    .o_conv_start(cst), .o_twelve_bit(tw), .i_conv_done(cdone),
    .i_conv_data(cdata));
  abc_core_model core (.i_sys_clk(clk), .i_start(cst), .i_slow(slow),
    .i_value(val), .o_done(cdone), .o_data(cdata));
  always @(posedge clk) begin
    if (cst === 1'b1) n_st++;
    if (win === 1'b1) n_win++;
    if (trk === 1'b1) n_trk++;
  end
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk) #1;
    wr = 1'b0;
    @(posedge clk) #1;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(posedge clk) #1;
    rd = 1'b0;
    d = rdata;
    @(posedge clk) #1;
  endtask
  task automatic chk_res(input logic [15:0] exp);
    logic [7:0] lo, hi;
    sfr_rd(ADDR_RES_LOW, lo);
    sfr_rd(ADDR_RES_HIGH, hi);
    check("result_sfr", {hi, lo}, exp);
    check("result_port", res, exp);
  endtask
  // Starts are always separated by far more than four clocks.
  task automatic run(input int n, output int l);
    int k;
    dclr = 1'b1;
    @(posedge clk) #1;
    dclr = 1'b0;
    n_st = 0;
    n_win = 0;
    n_trk = 0;
    l = 0;
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    for (k = 0; k < 5000 && done !== 1'b1; k++) begin
      @(posedge clk) #1;
      if (n_st == 0) l++;
    end
    check("done", {15'h0000, done}, 16'h0001);
    check("starts_at_done", 16'(n_st), 16'(n));
    repeat (3) @(posedge clk);
    #1;
    check("starts", 16'(n_st), 16'(n));
    check("window", 16'(n_win), 16'h0001);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(20000 * 8);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    sfr_rd(ADDR_ACC_CFG, rv);
    check("cfg_reset", {8'h00, rv}, {8'h00, ACC_CFG_RESET});
    chk_res(16'h0000);
    sfr_wr(ADDR_ACC_CFG, 8'h4a);
    sfr_rd(ADDR_ACC_CFG, rv);
    check("cfg_rd", {8'h00, rv}, 16'h000a);
    sfr_rd(8'h55, rv);
    check("unmapped", {8'h00, rv}, 16'h0000);
    check("mux", {11'h000, selo}, 16'h0013);
    sel = 5'h0c;
    @(posedge clk) #1;
    check("mux_chg", {11'h000, selo}, 16'h000c);
    $display("test registers done");
    burst = 1'b1;
    for (c = 0; c < 6; c++) begin
      sfr_wr(ADDR_ACC_CFG, 8'(c));
      run((c == 0) ? 1 : (2 << c), lat);
      if (c == 0) lc = lat;
      chk_res(16'(((c == 0) ? 1 : (2 << c)) * 12'h0a5));
      check("power_off", {15'h0000, pwr}, 16'h0000);
    end
    sfr_wr(ADDR_ACC_CFG, 8'h00);
    pwt = 5'h01;
    run(1, lat);
    pwt = 5'h00;
    check("pwrup", 16'((lat - lc) inside {[4*DIV-1:4*DIV+1]}), 16'h1);
    $display("test repeat counts done");
    cen = 1'b1;
    sfr_wr(ADDR_ACC_CFG, 8'h00);
    run(1, lat);
    run(1, lw);
    check("trk_len", 16'(n_trk inside {[DIV+1:2*DIV]}), 16'h1);
    check("power_on", {15'h0000, pwr}, 16'h0001);
    check("cold_wait", 16'(lc > lw), 16'h0001);
    check("warm_fast", 16'(lw <= 4 * DIV + 3), 16'h0001);
    xtra = 1'b1;
    run(1, lx);
    xtra = 1'b0;
    check("extra", 16'((lx - lw) inside {[3*DIV-1:3*DIV+1]}), 16'h1);
    tk = 4'h3;
    run(1, lt);
    tk = 4'h1;
    check("track", 16'((lt - lw) inside {[2*DIV-1:2*DIV+1]}), 16'h1);
    $display("test power and tracking done");
    for (c = 0; c < 4; c++) begin
      sfr_wr(ADDR_ACC_CFG, 8'((c << 3) | 1));
      run(4, lat);
      chk_res(16'h0294 >> c);
    end
    val = 12'h9a5;
    sfr_wr(ADDR_ACC_CFG, 8'h20);
    run(1, lat);
    chk_res(16'h6940);
    sfr_wr(ADDR_ACC_CFG, 8'ha0);
    run(1, lat);
    chk_res(16'h9a50);
    check("twelve", {15'h0000, tw}, 16'h0001);
    $display("test format done");
    burst = 1'b0;
    slow = 1'b1;
    val = 12'h0a5;
    sfr_wr(ADDR_ACC_CFG, 8'h40);
    sfr_wr(ADDR_RES_HIGH, 8'h00);
    sfr_wr(ADDR_RES_LOW, 8'h00);
    run(1, lat);
    run(1, lat);
    chk_res(16'h014a);
    sfr_wr(ADDR_ACC_CFG, 8'h00);
    run(1, lat);
    chk_res(16'h00a5);
    $display("test single mode done");
    test_done();
  end
endmodule
`default_nettype wire
